// ===== rtl/fsb_data_regs.svh
/*
 * Timing and encoding constants of the front side bus data phase controller.
 * Assumes the bench bus clock is slow enough that eight core clocks span one period.
 */
`ifndef FSB_DATA_REGS_SVH
`define FSB_DATA_REGS_SVH

// ==========================================================================
// Bus rates
// ==========================================================================
`define FSB_BUS_CLK_MHZ 133
`define FSB_XFER_MHZ 533
`define FSB_PUMP_BEATS 4
`define FSB_CORE_PERIOD_NS 50
`define FSB_BENCH_BCLK_NS 400
// Core cycles per bus clock, and the last phase index of one bus clock.
`define FSB_PHASES (`FSB_BENCH_BCLK_NS / `FSB_CORE_PERIOD_NS)
`define FSB_PHASE_LAST 3'h7

// ==========================================================================
// Data bus layout
// ==========================================================================
`define FSB_DATA_W 64
`define FSB_GROUPS 4
`define FSB_GROUP_W 16
`define FSB_INV_THRESHOLD 5'h08
`define FSB_BSEL_DEFAULT 2'h1

`endif

// ===== rtl/fsb_data_pkg.sv
/*
 * Types of the front side bus data phase controller.
 * Assumes nothing of its surroundings.
 */
package fsb_data_pkg;

    // ======================================================================
    // Controller states
    // ======================================================================
    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_OWN = 2'b10
    } own_state_t;

endpackage

// ===== rtl/fsb_tx_fifo.sv
/*
 * Small synchronous FIFO that holds outgoing bus words.
 * Assumes one clock and a synchronous active-low reset.
 */
`timescale 1ns/1ps
module fsb_tx_fifo #(
    parameter int WIDTH = 64,
    parameter int DEPTH = 4
) (
    input wire logic core_clk_in,
    input wire logic rstn_in,
    input wire logic wr_valid_in,
    output logic wr_ready_out,
    input wire logic [WIDTH-1:0] wr_data_in,
    output logic rd_valid_out,
    input wire logic rd_ready_in,
    output logic [WIDTH-1:0] rd_data_out,
    output logic full_out
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW-1:0] wr_ptr_r;
    logic [AW-1:0] rd_ptr_r;
    logic [AW:0] count_r;
    logic do_wr;
    logic do_rd;

    assign full_out = (count_r == (AW+1)'(DEPTH));
    assign wr_ready_out = !full_out;
    assign rd_valid_out = (count_r != '0);
    assign rd_data_out = mem_r[rd_ptr_r];
    assign do_wr = wr_valid_in && wr_ready_out;
    assign do_rd = rd_valid_out && rd_ready_in;

    function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
        ptr_inc = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
    endfunction

    always_ff @(posedge core_clk_in) begin
        if (do_wr) begin
            mem_r[wr_ptr_r] <= wr_data_in;
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (!rstn_in) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r <= '0;
        end else begin
            if (do_wr) begin
                wr_ptr_r <= ptr_inc(wr_ptr_r);
            end
            if (do_rd) begin
                rd_ptr_r <= ptr_inc(rd_ptr_r);
            end
            if (do_wr && !do_rd) begin
                count_r <= count_r + 1'b1;
            end else if (do_rd && !do_wr) begin
                count_r <= count_r - 1'b1;
            end
        end
    end
endmodule // fsb_tx_fifo

// ===== rtl/fsb_data_host.sv
/*
 * Chipset-side data phase controller of a quad-pumped front side bus.
 * Assumes the bus clock, strobes and bus lines arrive asynchronously and that
 * eight core clocks span one bus clock; pins are resolved from the enables outside.
 */
`timescale 1ns/1ps
`include "fsb_data_regs.svh"

// Functional notes
// - All agents run one common rate: 533 MHz transfers from 133 MHz clock.
// - Data path is 64 bits, each line wired pin to pin between agents.
// - The data source asserts active-low data-ready for every valid transfer.
// - Four data values are presented per bus clock period.
// - Receiver captures on falling edges of positive then negative strobe, alternating.
// - Four 16-bit groups, lowest first; group k uses strobe pair k, inversion k.
// - Each group has exactly one active-low inversion line sent with it.
// - Asserted inversion means bits driven inverted and read as active high.
// - The driving agent holds data-bus-busy asserted while it occupies the bus.
// - Bus is free only after data-bus-busy deasserts.
// - In multi-clock transfers data-ready may drop to insert idle clocks.
// - Outputs and common-clock samples are referenced to the bus clock rising edge.
module fsb_data_host #(
    parameter int DATA_W = `FSB_DATA_W,
    parameter int FIFO_DEPTH = `FSB_PUMP_BEATS,
    parameter logic [1:0] EXPECT_BSEL = `FSB_BSEL_DEFAULT
) (
    input wire logic core_clk_in,
    input wire logic rstn_in,
    input wire logic bus_clk_in,
    input wire logic [1:0] bus_freq_select_in,
    output logic freq_mismatch_out,
    input wire logic [DATA_W-1:0] data_n_in,
    output logic [DATA_W-1:0] data_n_out,
    output logic data_n_oe_out,
    input wire logic [3:0] group_invert_n_in,
    output logic [3:0] group_invert_n_out,
    output logic group_invert_n_oe_out,
    input wire logic [3:0] data_strobe_pos_in,
    output logic [3:0] data_strobe_pos_out,
    input wire logic [3:0] data_strobe_neg_in,
    output logic [3:0] data_strobe_neg_out,
    output logic data_strobe_oe_out,
    input wire logic data_valid_n_in,
    output logic data_valid_n_out,
    output logic data_valid_n_oe_out,
    input wire logic data_bus_occupied_n_in,
    output logic data_bus_occupied_n_out,
    output logic data_bus_occupied_n_oe_out,
    input wire logic tx_valid_in,
    output logic tx_ready_out,
    input wire logic [DATA_W-1:0] tx_data_in,
    input wire logic tx_more_in,
    output logic rx_valid_out,
    output logic [DATA_W-1:0] rx_data_out
);
    localparam int GW = `FSB_GROUP_W;
    localparam int SW = 1 + 2 + DATA_W + 4 + 4 + 4 + 1 + 1;

    // ======================================================================
    // Input synchronisers
    // ======================================================================
    logic [SW-1:0] sync1_r;
    logic [SW-1:0] sync2_r;
    logic bclk_d_r;
    logic [3:0] pos_d_r;
    logic [3:0] neg_d_r;

    logic s_bclk;
    logic [1:0] s_bsel;
    logic [DATA_W-1:0] s_data_n;
    logic [3:0] s_inv_n;
    logic [3:0] s_pos;
    logic [3:0] s_neg;
    logic s_data_valid_n_n;
    logic s_data_bus_occupied_n_n;

    always_ff @(posedge core_clk_in) begin
        if (!rstn_in) begin
            sync1_r <= {1'b1, EXPECT_BSEL, {(SW-3){1'b1}}};
            sync2_r <= {1'b1, EXPECT_BSEL, {(SW-3){1'b1}}};
        end else begin
            sync1_r <= {bus_clk_in, bus_freq_select_in, data_n_in, group_invert_n_in,
                        data_strobe_pos_in, data_strobe_neg_in, data_valid_n_in, data_bus_occupied_n_in};
            sync2_r <= sync1_r;
        end
    end

    assign {s_bclk, s_bsel, s_data_n, s_inv_n, s_pos, s_neg, s_data_valid_n_n, s_data_bus_occupied_n_n} = sync2_r;

    always_ff @(posedge core_clk_in) begin
        if (!rstn_in) begin
            bclk_d_r <= 1'b1;
            pos_d_r <= 4'hf;
            neg_d_r <= 4'hf;
        end else begin
            bclk_d_r <= s_bclk;
            pos_d_r <= s_pos;
            neg_d_r <= s_neg;
        end
    end

    // ======================================================================
    // Group encoding
    // ======================================================================
    // Inverting caps the lines pulled low at eight when most bits are ones.
    function automatic logic want_invert(input logic [GW-1:0] d);
        logic [4:0] ones;
        ones = '0;
        for (int i = 0; i < GW; i++) begin
            ones = ones + 5'(d[i]);
        end
        want_invert = (ones > `FSB_INV_THRESHOLD);
    endfunction

    // Active-low pin levels turn into data; an asserted inversion flips that.
    function automatic logic [GW-1:0] group_decode(input logic [GW-1:0] pins, input logic inv_n);
        group_decode = inv_n ? ~pins : pins;
    endfunction

    // ======================================================================
    // Bus clock phase and frequency check
    // ======================================================================
    logic bclk_rise;
    logic [2:0] phase_r;
    logic freq_mismatch_r;

    assign bclk_rise = s_bclk && !bclk_d_r;

    always_ff @(posedge core_clk_in) begin
        if (!rstn_in) begin
            phase_r <= `FSB_PHASE_LAST;
        end else if (bclk_rise) begin
            phase_r <= 3'h0;
        end else if (phase_r != `FSB_PHASE_LAST) begin
            phase_r <= phase_r + 3'h1;
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (!rstn_in) begin
            freq_mismatch_r <= 1'b0;
        end else begin
            freq_mismatch_r <= (s_bsel != EXPECT_BSEL);
        end
    end

    assign freq_mismatch_out = freq_mismatch_r;

    // ======================================================================
    // Transmit FIFO
    // ======================================================================
    logic fifo_valid;
    logic fifo_pop;
    logic fifo_full;
    logic [DATA_W-1:0] fifo_data;

    fsb_tx_fifo #(
        .WIDTH(DATA_W),
        .DEPTH(FIFO_DEPTH)
    ) u_tx_fifo (
        .core_clk_in(core_clk_in),
        .rstn_in(rstn_in),
        .wr_valid_in(tx_valid_in),
        .wr_ready_out(tx_ready_out),
        .wr_data_in(tx_data_in),
        .rd_valid_out(fifo_valid),
        .rd_ready_in(fifo_pop),
        .rd_data_out(fifo_data),
        .full_out(fifo_full)
    );

    // ======================================================================
    // Ownership state machine
    // ======================================================================
    fsb_data_pkg::own_state_t state_r;
    logic quad_r;
    logic bus_free;

    assign bus_free = s_data_bus_occupied_n_n && s_data_valid_n_n;

    always_ff @(posedge core_clk_in) begin
        if (!rstn_in) begin
            state_r <= fsb_data_pkg::ST_IDLE;
            quad_r <= 1'b0;
        end else if (bclk_rise) begin
            case (state_r)
                fsb_data_pkg::ST_IDLE: begin
                    if (fifo_full && bus_free) begin
                        state_r <= fsb_data_pkg::ST_OWN;
                        quad_r <= 1'b1;
                    end
                end
                fsb_data_pkg::ST_OWN: begin
                    if (fifo_full) begin
                        quad_r <= 1'b1;
                    end else if (tx_more_in) begin
                        quad_r <= 1'b0;
                    end else begin
                        state_r <= fsb_data_pkg::ST_IDLE;
                        quad_r <= 1'b0;
                    end
                end
                default: begin
                    state_r <= fsb_data_pkg::ST_IDLE;
                    quad_r <= 1'b0;
                end
            endcase
        end
    end

    // ======================================================================
    // Transmit beats
    // ======================================================================
    logic owning;
    logic sending;
    logic [DATA_W-1:0] data_n_r;
    logic [3:0] inv_n_r;
    logic [3:0] pos_r;
    logic [3:0] neg_r;
    logic data_valid_n_n_r;
    logic data_bus_occupied_n_n_r;

    assign owning = (state_r == fsb_data_pkg::ST_OWN);
    assign sending = owning && quad_r;
    // A beat leaves the FIFO on every even phase, four per bus clock.
    assign fifo_pop = sending && !phase_r[0] && fifo_valid;

    always_ff @(posedge core_clk_in) begin
        if (!rstn_in) begin
            data_n_r <= {DATA_W{1'b1}};
            inv_n_r <= 4'hf;
        end else if (fifo_pop) begin
            for (int g = 0; g < `FSB_GROUPS; g++) begin
                if (want_invert(fifo_data[g*GW +: GW])) begin
                    data_n_r[g*GW +: GW] <= fifo_data[g*GW +: GW];
                    inv_n_r[g] <= 1'b0;
                end else begin
                    data_n_r[g*GW +: GW] <= ~fifo_data[g*GW +: GW];
                    inv_n_r[g] <= 1'b1;
                end
            end
        end
    end

    // Strobes fall one cycle after the data settle and rise as the next beat loads.
    always_ff @(posedge core_clk_in) begin
        if (!rstn_in) begin
            pos_r <= 4'hf;
            neg_r <= 4'hf;
        end else begin
            pos_r <= (sending && phase_r[0] && !phase_r[1]) ? 4'h0 : 4'hf;
            neg_r <= (sending && phase_r[0] && phase_r[1]) ? 4'h0 : 4'hf;
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (!rstn_in) begin
            data_valid_n_n_r <= 1'b1;
            data_bus_occupied_n_n_r <= 1'b1;
        end else begin
            data_valid_n_n_r <= !sending;
            data_bus_occupied_n_n_r <= !owning;
        end
    end

    assign data_n_out = data_n_r;
    assign group_invert_n_out = inv_n_r;
    assign data_strobe_pos_out = pos_r;
    assign data_strobe_neg_out = neg_r;
    assign data_valid_n_out = data_valid_n_n_r;
    assign data_bus_occupied_n_out = data_bus_occupied_n_n_r;
    assign data_n_oe_out = !data_bus_occupied_n_n_r;
    assign group_invert_n_oe_out = !data_bus_occupied_n_n_r;
    assign data_strobe_oe_out = !data_bus_occupied_n_n_r;
    assign data_valid_n_oe_out = !data_bus_occupied_n_n_r;
    assign data_bus_occupied_n_oe_out = !data_bus_occupied_n_n_r;

    // ======================================================================
    // Receive capture
    // ======================================================================
    logic rx_on;
    logic [3:0] grp_fall;
    logic [3:0] got_r;
    logic all_got;
    logic [DATA_W-1:0] rx_grp_r;
    logic [DATA_W-1:0] rx_data_r;
    logic rx_valid_r;
    logic [1:0] own_hist_r;

    assign rx_on = !owning && data_bus_occupied_n_n_r && (own_hist_r == 2'h0) && !s_data_valid_n_n;
    assign grp_fall = rx_on ? ((pos_d_r & ~s_pos) | (neg_d_r & ~s_neg)) : 4'h0;
    assign all_got = &got_r;

    // Own strobes echo back through the synchronisers for two cycles.
    always_ff @(posedge core_clk_in) begin
        own_hist_r <= {own_hist_r[0], !data_bus_occupied_n_n_r};
    end

    always_ff @(posedge core_clk_in) begin
        if (!rstn_in) begin
            rx_grp_r <= '0;
        end else begin
            for (int g = 0; g < `FSB_GROUPS; g++) begin
                if (grp_fall[g]) begin
                    rx_grp_r[g*GW +: GW] <= group_decode(s_data_n[g*GW +: GW], s_inv_n[g]);
                end
            end
        end
    end

    // A fall that arrives as the word completes starts the next word.
    always_ff @(posedge core_clk_in) begin
        if (!rstn_in) begin
            got_r <= 4'h0;
        end else begin
            got_r <= (got_r & ~{4{all_got}}) | grp_fall;
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (!rstn_in) begin
            rx_valid_r <= 1'b0;
            rx_data_r <= '0;
        end else begin
            rx_valid_r <= all_got;
            if (all_got) begin
                rx_data_r <= rx_grp_r;
            end
        end
    end

    assign rx_valid_out = rx_valid_r;
    assign rx_data_out = rx_data_r;
endmodule // fsb_data_host

// ===== testbench/fsb_data_host_sva.sv
/* Checker of the front side bus data phase controller, bound to its ports.
   Assumes one core clock domain with a synchronous active-low reset. */
`timescale 1ns/1ps
module fsb_data_host_sva #(
    parameter int DATA_W = 64,
    parameter logic [1:0] EXPECT_BSEL = 2'h1
) (
    input wire logic core_clk_in,
    input wire logic rstn_in,
    input wire logic [1:0] bus_freq_select_in,
    input wire logic freq_mismatch_out,
    input wire logic [DATA_W-1:0] data_n_out,
    input wire logic data_n_oe_out,
    input wire logic [3:0] group_invert_n_out,
    input wire logic group_invert_n_oe_out,
    input wire logic [3:0] data_strobe_pos_out,
    input wire logic [3:0] data_strobe_neg_out,
    input wire logic data_strobe_oe_out,
    input wire logic data_valid_n_in,
    input wire logic data_valid_n_out,
    input wire logic data_valid_n_oe_out,
    input wire logic data_bus_occupied_n_in,
    input wire logic data_bus_occupied_n_out,
    input wire logic data_bus_occupied_n_oe_out,
    input wire logic tx_ready_out,
    input wire logic rx_valid_out
);
    // ==========
    // Helpers
    // ==========
    // True when no group pulls more than eight lines low, nor more than seven with its inversion asserted.
    function automatic bit enc_ok(logic [DATA_W-1:0] d, logic [3:0] inv);
        enc_ok = 1'b1;
        for (int g = 0; g < 4; g++) begin
            if ($countones(d[g*16 +: 16]) < (inv[g] ? 8 : 9)) enc_ok = 1'b0;
        end
    endfunction
    default clocking cb @(posedge core_clk_in);
    endclocking
    default disable iff (!rstn_in);
    // ==========
    // Assertions
    // ==========
    a_oe_follow: assert property (
        {data_n_oe_out, group_invert_n_oe_out, data_strobe_oe_out, data_valid_n_oe_out, data_bus_occupied_n_oe_out}
        == {5{!data_bus_occupied_n_out}}) else $error("enables differ from ownership");
    a_valid_own: assert property (
        !data_valid_n_out |-> !data_bus_occupied_n_out && data_valid_n_oe_out) else $error("valid without ownership");
    a_strobe_valid: assert property (
        data_strobe_oe_out && !(&data_strobe_pos_out && &data_strobe_neg_out)
        |-> !data_valid_n_out || !$past(data_valid_n_out)) else $error("strobe outside valid");
    a_data_stable: assert property (
        $fell(data_strobe_pos_out[0]) |-> $stable(data_n_out) && $stable(group_invert_n_out)
        ##1 $rose(data_strobe_pos_out[0])) else $error("data moved at strobe");
    a_inv_encode: assert property (
        data_n_oe_out |-> enc_ok(data_n_out, group_invert_n_out)) else $error("bad group inversion");
    a_quad_beats: assert property (
        $fell(data_valid_n_out) |-> ##1 data_strobe_pos_out == 4'h0 ##2 data_strobe_neg_out == 4'h0
        ##2 data_strobe_pos_out == 4'h0 ##2 data_strobe_neg_out == 4'h0) else $error("beats out of place");
    a_start_free: assert property (
        $fell(data_bus_occupied_n_out) |-> $past(data_bus_occupied_n_in, 4) && $past(data_valid_n_in, 4))
        else $error("start on occupied bus");
    a_freq_match: assert property (
        (bus_freq_select_in == EXPECT_BSEL) [*5] |-> !freq_mismatch_out) else $error("false frequency mismatch");
    a_freq_miss: assert property (
        (bus_freq_select_in != EXPECT_BSEL) [*5] |-> freq_mismatch_out) else $error("missed frequency mismatch");
    c_tx: cover property ($fell(data_bus_occupied_n_out));
    c_rx: cover property (rx_valid_out);
    c_full: cover property (!tx_ready_out);
    c_freq: cover property ($rose(freq_mismatch_out));
endmodule // fsb_data_host_sva

bind fsb_data_host fsb_data_host_sva #(.DATA_W(DATA_W), .EXPECT_BSEL(EXPECT_BSEL)) i_fsb_data_host_sva (
    .core_clk_in, .rstn_in, .bus_freq_select_in, .freq_mismatch_out, .data_n_out, .data_n_oe_out,
    .group_invert_n_out, .group_invert_n_oe_out, .data_strobe_pos_out, .data_strobe_neg_out, .data_strobe_oe_out,
    .data_valid_n_in, .data_valid_n_out, .data_valid_n_oe_out, .data_bus_occupied_n_in, .data_bus_occupied_n_out,
    .data_bus_occupied_n_oe_out, .tx_ready_out, .rx_valid_out);

// ===== testbench/fsb_cpu_model.sv
/* Behavioural model of the processor at the far side of the shared data bus.
   Assumes the bench resolves every line from both enables, terminated high. */
`timescale 1ns/1ps
module fsb_cpu_model (
    input wire logic bus_clk_in,
    input wire logic [63:0] data_n_in,
    input wire logic [3:0] group_invert_n_in,
    input wire logic [3:0] data_strobe_pos_in,
    input wire logic [3:0] data_strobe_neg_in,
    input wire logic data_bus_occupied_n_in,
    output logic [1:0] bus_freq_select_out,
    output logic [63:0] data_n_out,
    output logic [3:0] group_invert_n_out,
    output logic [3:0] data_strobe_pos_out,
    output logic [3:0] data_strobe_neg_out,
    output logic data_valid_n_out,
    output logic data_bus_occupied_n_out,
    output logic oe_out
);
    logic [1:0] freq_sel = 2'h1;
    logic [16:0] got [4][$];
    assign bus_freq_select_out = freq_sel;
    initial begin
        oe_out = 1'b0;
        data_n_out = '1;
        group_invert_n_out = '1;
        data_strobe_pos_out = '1;
        data_strobe_neg_out = '1;
        data_valid_n_out = 1'b1;
        data_bus_occupied_n_out = 1'b1;
    end
    // ==========
    // Receive
    // ==========
    for (genvar g = 0; g < 4; g++) begin : g_cap
        always @(negedge data_strobe_pos_in[g] or negedge data_strobe_neg_in[g]) begin
            if (!oe_out) got[g].push_back({group_invert_n_in[g], data_n_in[g*16 +: 16]});
        end
    end
    task automatic clear;
        for (int g = 0; g < 4; g++) got[g].delete();
    endtask
    // ==========
    // Send
    // ==========
    // Released mid-period, so the release and a clock rise never meet in one sample.
    task automatic hold(input logic on);
        @(negedge bus_clk_in);
        oe_out = on;
        data_bus_occupied_n_out = !on;
    endtask
    task automatic xfer(input logic [255:0] q, input logic keep);
        logic [15:0] d;
        logic inv;
        do @(posedge bus_clk_in); while (data_bus_occupied_n_in !== 1'b1 && !oe_out);
        oe_out = 1'b1;
        data_bus_occupied_n_out = 1'b0;
        data_valid_n_out = 1'b0;
        for (int b = 0; b < 4; b++) begin
            for (int g = 0; g < 4; g++) begin
                d = q[b*64 + g*16 +: 16];
                inv = !($countones(d) > 8);
                group_invert_n_out[g] = inv;
                data_n_out[g*16 +: 16] = inv ? ~d : d;
            end
            data_strobe_pos_out = '1;
            data_strobe_neg_out = '1;
            #50;
            if (b[0]) data_strobe_neg_out = '0;
            else data_strobe_pos_out = '0;
            if (b < 3) #50;
            else @(posedge bus_clk_in);
        end
        data_strobe_neg_out = '1;
        data_valid_n_out = 1'b1;
        if (!keep) begin
            oe_out = 1'b0;
            data_bus_occupied_n_out = 1'b1;
        end
    endtask
endmodule // fsb_cpu_model

// ===== testbench/fsb_data_host_tb.sv
/* Self-checking bench of the front side bus data phase controller.
   Assumes the device model and the bound checker are compiled alongside. */
`timescale 1ns/1ps
module fsb_data_host_tb;
    logic core_clk_in = 1'b0;
    logic rstn_in = 1'b0;
    logic bus_clk = 1'b0;
    logic tx_valid_in = 1'b0;
    logic tx_more_in = 1'b0;
    logic [63:0] tx_data_in = 64'h0;
    logic [63:0] h_d, c_d, d_w, rx_data_out;
    logic [3:0] h_i, c_i, i_w, h_p, c_p, p_w, h_n, c_n, n_w;
    logic [1:0] sel;
    logic h_doe, h_ioe, h_soe, h_voe, h_boe, c_oe, h_v, c_v, v_w, h_b, c_b, b_w;
    logic tx_ready_out, rx_valid_out, freq_mismatch_out;
    logic [63:0] rxq [$];
    logic [63:0] pat [8] = '{64'h01ff_00ff_ffff_0000, 64'h0000_ffff_00ff_01ff, 64'h8000_7fff_fe01_1234,
        64'hfffe_0001_aaaa_5555, 64'hff80_01fe_0f0f_f0f0, 64'h1111_eeee_7f80_80ff, 64'hdead_beef_0123_4567,
        64'h0fff_f000_3c3c_c3c7};
    int n_fail = 0;
    int n_tests = 0;
    int cycles = 0;
    always #25 core_clk_in = ~core_clk_in;
    always #200 bus_clk = ~bus_clk;
    // Lines idle high through their termination when nobody drives them.
    assign d_w = h_doe === 1'b1 ? h_d : (c_oe ? c_d : '1);
    assign i_w = h_ioe === 1'b1 ? h_i : (c_oe ? c_i : '1);
    assign p_w = h_soe === 1'b1 ? h_p : (c_oe ? c_p : '1);
    assign n_w = h_soe === 1'b1 ? h_n : (c_oe ? c_n : '1);
    assign v_w = h_voe === 1'b1 ? h_v : (c_oe ? c_v : 1'b1);
    assign b_w = h_boe === 1'b1 ? h_b : (c_oe ? c_b : 1'b1);
    fsb_data_host #(.DATA_W(64), .FIFO_DEPTH(4), .EXPECT_BSEL(2'h1)) i_fsb_data_host (.core_clk_in, .rstn_in,
        .bus_clk_in(bus_clk), .bus_freq_select_in(sel), .freq_mismatch_out, .data_n_in(d_w), .data_n_out(h_d),
        .data_n_oe_out(h_doe), .group_invert_n_in(i_w), .group_invert_n_out(h_i), .group_invert_n_oe_out(h_ioe),
        .data_strobe_pos_in(p_w), .data_strobe_pos_out(h_p), .data_strobe_neg_in(n_w), .data_strobe_neg_out(h_n),
        .data_strobe_oe_out(h_soe), .data_valid_n_in(v_w), .data_valid_n_out(h_v), .data_valid_n_oe_out(h_voe),
        .data_bus_occupied_n_in(b_w), .data_bus_occupied_n_out(h_b), .data_bus_occupied_n_oe_out(h_boe),
        .tx_valid_in, .tx_ready_out, .tx_data_in, .tx_more_in, .rx_valid_out, .rx_data_out);
    fsb_cpu_model i_fsb_cpu_model (.bus_clk_in(bus_clk), .data_n_in(d_w), .group_invert_n_in(i_w),
        .data_strobe_pos_in(p_w), .data_strobe_neg_in(n_w), .data_bus_occupied_n_in(b_w), .bus_freq_select_out(sel),
        .data_n_out(c_d), .group_invert_n_out(c_i), .data_strobe_pos_out(c_p), .data_strobe_neg_out(c_n),
        .data_valid_n_out(c_v), .data_bus_occupied_n_out(c_b), .oe_out(c_oe));
    // ==========
    // Checking
    // ==========
    task automatic chk_word(input logic [63:0] got, input logic [63:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch at %0t: word %h, expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_bit(input logic got, input logic exp);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch at %0t: flag %b, expected %b", $time, got, exp);
        end
    endtask
    task automatic conclude;
        if (n_fail == 0 && n_tests > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    always @(negedge core_clk_in) begin
        if (rx_valid_out === 1'b1) rxq.push_back(rx_data_out);
        cycles++;
        if (cycles == 3000) begin
            n_fail++;
            $display("mismatch at %0t: timeout", $time);
            conclude;
        end
    end
    // ==========
    // Drivers
    // ==========
    task automatic push(input logic [63:0] d);
        @(negedge core_clk_in);
        tx_valid_in = 1'b1;
        tx_data_in = d;
        while (tx_ready_out !== 1'b1) @(negedge core_clk_in);
        @(posedge core_clk_in);
    endtask
    task automatic wait_sent(input int first, input int n);
        logic [15:0] d;
        logic inv;
        for (int i = 0; i < 400 && i_fsb_cpu_model.got[3].size() < n; i++) @(negedge core_clk_in);
        for (int w = 0; w < n; w++) begin
            for (int g = 0; g < 4; g++) begin
                d = pat[first+w][g*16 +: 16];
                inv = !($countones(d) > 8);
                chk_word(64'(i_fsb_cpu_model.got[g][w]), 64'({inv, inv ? ~d : d}));
            end
        end
        i_fsb_cpu_model.clear();
    endtask
    // ==========
    // Scenarios
    // ==========
    task automatic t_reset;
        chk_bit(h_doe | h_ioe | h_soe | h_voe | h_boe, 1'b0);
        chk_bit(tx_ready_out, 1'b1);
        chk_bit(rx_valid_out, 1'b0);
        chk_word(h_d, '1);
        chk_bit(freq_mismatch_out, 1'b0);
        i_fsb_cpu_model.clear();
    endtask
    task automatic t_freq;
        for (int s = 0; s < 4; s++) begin
            i_fsb_cpu_model.freq_sel = 2'(s);
            repeat (8) @(negedge core_clk_in);
            chk_bit(freq_mismatch_out, 2'(s) != 2'h1);
        end
        i_fsb_cpu_model.freq_sel = 2'h1;
    endtask
    task automatic t_stall;
        i_fsb_cpu_model.hold(1'b1);
        for (int w = 0; w < 4; w++) push(pat[w]);
        @(negedge core_clk_in);
        chk_bit(tx_ready_out, 1'b0);
        tx_valid_in = 1'b0;
        repeat (24) @(negedge core_clk_in);
        chk_bit(h_doe, 1'b0);
        i_fsb_cpu_model.hold(1'b0);
        wait_sent(0, 4);
        repeat (24) @(negedge core_clk_in);
        chk_bit(h_boe, 1'b0);
        chk_bit(tx_ready_out, 1'b1);
    endtask
    task automatic t_burst;
        tx_more_in = 1'b1;
        for (int w = 0; w < 8; w++) push(pat[w]);
        @(negedge core_clk_in);
        tx_valid_in = 1'b0;
        wait_sent(0, 8);
        repeat (16) @(negedge core_clk_in);
        chk_bit(h_b, 1'b0);
        chk_bit(h_v, 1'b1);
        tx_more_in = 1'b0;
        repeat (24) @(negedge core_clk_in);
        chk_bit(h_boe, 1'b0);
    endtask
    task automatic t_rx;
        chk_word(64'(rxq.size()), 64'h0);
        rxq.delete();
        i_fsb_cpu_model.xfer({pat[3], pat[2], pat[1], pat[0]}, 1'b1);
        i_fsb_cpu_model.xfer({pat[7], pat[6], pat[5], pat[4]}, 1'b0);
        repeat (16) @(negedge core_clk_in);
        chk_word(64'(rxq.size()), 64'h8);
        for (int w = 0; w < 8; w++) chk_word(rxq[w], pat[w]);
    endtask
    initial begin
        repeat (20) @(negedge core_clk_in);
        rstn_in = 1'b1;
        @(negedge core_clk_in);
        t_reset;
        t_freq;
        t_stall;
        t_burst;
        t_rx;
        conclude;
    end
endmodule // fsb_data_host_tb
